// File: dv/rfp_patch_unit_bench.sv
// Purpose: Self-checking bench for the fetch patch unit
// Assumes: Inputs driven on the falling edge
// Notes: ROM bytes come from the partner model
`timescale 1ns/1ps
`default_nettype none
`include "rfp_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module rfp_patch_unit_bench;
	logic        core_clk;
	logic        resetn = 0, sfr_wr = 0, sfr_rd = 0, sfr_bit_op = 0, sfr_bit_val = 0;
	logic        fetch_req = 0, fetch_instr = 0, fetch_first = 0, fetch_internal = 0;
	logic [2:0]  sfr_bit_pos = 0;
	logic [15:0] sfr_wdata = 0, sfr_rdata_r, table_entry_r;
	logic [19:0] sfr_addr = 0, fetch_addr = 0;
	logic [7:0]  rom_data, fetch_data_r;
	logic        sfr_rack_r, fetch_valid_r, table_call_r;
	int          fails = 0, checked = 0;
	rfp_patch_unit rfp_patch_unit_inst (.core_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_word(1'b0),
		.sfr_bit_op, .sfr_bit_pos, .sfr_bit_val, .sfr_wdata, .sfr_rdata_r, .sfr_rack_r, .fetch_req,
		.fetch_addr, .fetch_instr, .fetch_first, .fetch_internal, .rom_data, .fetch_data_r,
		.fetch_valid_r, .table_call_r, .table_entry_r);
	rfp_rom_model rfp_rom_model_inst (.addr(fetch_addr), .data(rom_data));
	function automatic [7:0] rom(input [19:0] a);
		return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
	endfunction
	// Distinct high nibbles exercise all 20 bits
	function automatic [19:0] ptr(input [1:0] c);
		return {2'b01, c, 8'h5a, 6'h05, c};
	endfunction
	task automatic wreg(input [19:0] a, input [15:0] d, input b);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_bit_op = b;
		sfr_bit_pos = d[6:4];
		sfr_bit_val = d[0];
		sfr_wr = 1;
		@(negedge core_clk);
		sfr_wr = 0;
	endtask
	task automatic rreg(input [19:0] a, input [15:0] e);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge core_clk);
		sfr_rd = 0;
		// Ack and data stand in the second cycle after the request
		@(negedge core_clk);
		`CHK(sfr_rack_r, 1'b1)
		`CHK(sfr_rdata_r, e)
	endtask
	task automatic fch(input [19:0] a, input [2:0] k, input [7:0] e, input c);
		@(negedge core_clk);
		fetch_addr = a;
		{fetch_instr, fetch_first, fetch_internal} = k;
		fetch_req = 1;
		@(negedge core_clk);
		fetch_req = 0;
		`CHK(fetch_valid_r, 1'b1)
		`CHK(fetch_data_r, e)
		`CHK(table_call_r, c)
	endtask
	task automatic t_regs;
		rreg(`RFP_CTRL_ADDR, 16'h0000);
		fch(20'h00000, 3'b111, rom(20'h00000), 1'b0);
		wreg(`RFP_CTRL_ADDR, 16'h00ff, 1'b0);
		rreg(`RFP_CTRL_ADDR, 16'h00f3);
		wreg(`RFP_CTRL_ADDR, 16'h0021, 1'b1);
		rreg(`RFP_CTRL_ADDR, 16'h00f3);
		wreg(`RFP_CTRL_ADDR, 16'h0070, 1'b1);
		rreg(`RFP_CTRL_ADDR, 16'h0073);
		rreg(20'hff90, 16'h0000);
	endtask
	task automatic t_ptrs;
		for (int c = 0; c < 4; c++)
		begin
			wreg(`RFP_CTRL_ADDR, 16'(c), 1'b0);
			wreg(`RFP_ADDRL_ADDR, 16'(ptr(2'(c))), 1'b0);
			wreg(`RFP_ADDRH_ADDR, 16'(ptr(2'(c)) >> 16), 1'b0);
		end
		for (int c = 0; c < 4; c++)
		begin
			wreg(`RFP_CTRL_ADDR, 16'(c), 1'b0);
			rreg(`RFP_ADDRL_ADDR, 16'(ptr(2'(c))));
			rreg(`RFP_ADDRH_ADDR, 16'(ptr(2'(c)) >> 16));
		end
	endtask
	task automatic t_match;
		logic [15:0] sp;
		sp = 16'hfe00;
		wreg(`RFP_CTRL_ADDR, 16'h00f0, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			fch(ptr(2'(c)), 3'b111, {6'h3f, 2'(c)}, 1'b1);
			`CHK(table_entry_r, {9'h000, 4'hf, 2'(c), 1'b0})
			// Far side stack: the call saves three bytes, the patch routine drops them
			if (table_call_r)
				sp = sp - 16'(`RFP_STACK_SAVE);
			sp = sp + 16'(`RFP_STACK_SAVE);
			`CHK(sp, 16'hfe00)
			fch(ptr(2'(c)), 3'b011, rom(ptr(2'(c))), 1'b0);
			fch(ptr(2'(c)), 3'b101, rom(ptr(2'(c))), 1'b0);
			fch(ptr(2'(c)), 3'b110, rom(ptr(2'(c))), 1'b0);
			fch(ptr(2'(c)) ^ 20'h80000, 3'b111, rom(ptr(2'(c)) ^ 20'h80000), 1'b0);
		end
		wreg(`RFP_CTRL_ADDR, 16'h00e0, 1'b0);
		fch(ptr(2'd0), 3'b111, rom(ptr(2'd0)), 1'b0);
	endtask
	task automatic t_prio;
		wreg(`RFP_CTRL_ADDR, 16'h00f2, 1'b0);
		wreg(`RFP_ADDRL_ADDR, 16'(ptr(2'd1)), 1'b0);
		wreg(`RFP_ADDRH_ADDR, 16'(ptr(2'd1) >> 16), 1'b0);
		fch(ptr(2'd1), 3'b111, 8'hfd, 1'b1);
		wreg(`RFP_CTRL_ADDR, 16'h00d0, 1'b0);
		fch(ptr(2'd1), 3'b111, 8'hfe, 1'b1);
	endtask
	task automatic finish_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// Whole run needs about 150 cycles
	initial
	begin
		repeat (5000) @(posedge core_clk);
		fails++;
		finish_test();
	end
	initial
	begin
		repeat (10) @(negedge core_clk);
		resetn = 1;
		t_regs();
		t_ptrs();
		t_match();
		t_prio();
		finish_test();
	end
endmodule // rfp_patch_unit_bench
bind rfp_patch_unit rfp_props rfp_props_inst (.core_clk, .resetn, .sfr_addr, .sfr_rd, .sfr_rdata_r,
	.sfr_rack_r, .fetch_req, .fetch_instr, .fetch_first, .fetch_internal, .rom_data, .fetch_data_r,
	.fetch_valid_r, .table_call_r, .table_entry_r);
`default_nettype wire

// File: dv/rfp_props.sv
// Purpose: Port assertions for the fetch patch unit
// Assumes: Bound to rfp_patch_unit, one clock domain
// Notes: Fetch outputs are judged one edge after their cause, register read answers two edges after
`timescale 1ns/1ps
`default_nettype none
`include "rfp_regs.vh"
module rfp_props
(
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic [19:0] sfr_addr,
	input wire logic        sfr_rd,
	input wire logic [15:0] sfr_rdata_r,
	input wire logic        sfr_rack_r,
	input wire logic        fetch_req,
	input wire logic        fetch_instr,
	input wire logic        fetch_first,
	input wire logic        fetch_internal,
	input wire logic [7:0]  rom_data,
	input wire logic [7:0]  fetch_data_r,
	input wire logic        fetch_valid_r,
	input wire logic        table_call_r,
	input wire logic [15:0] table_entry_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence plain_fetch;
		fetch_req && !(fetch_instr && fetch_internal && fetch_first);
	endsequence
	sequence unmapped_rd;
		sfr_rd && sfr_addr != `RFP_CTRL_ADDR && sfr_addr != `RFP_ADDRL_ADDR && sfr_addr != `RFP_ADDRH_ADDR;
	endsequence
	plain_pass_a: assert property (plain_fetch |=> !table_call_r && fetch_data_r == $past(rom_data))
		else $error("plain fetch was altered");
	fetch_valid_a: assert property (##1 fetch_valid_r == $past(fetch_req))
		else $error("fetch answer timing wrong");
	call_valid_a: assert property (table_call_r |-> fetch_valid_r)
		else $error("call without fetch");
	opcode_entry_a: assert property (table_call_r |-> fetch_data_r[7:2] == 6'h3f
		&& table_entry_r == {9'h000, 4'hf, fetch_data_r[1:0], 1'b0})
		else $error("opcode and entry disagree");
	entry_idle_a: assert property (!table_call_r |-> table_entry_r == 16'h0000)
		else $error("entry set without call");
	read_ack_a: assert property (##2 sfr_rack_r == $past(sfr_rd, 2))
		else $error("read answer timing wrong");
	ctrl_zero_a: assert property (sfr_rd && sfr_addr == `RFP_CTRL_ADDR |-> ##2 sfr_rdata_r[3:2] == 2'b00)
		else $error("control reserved bits set");
	unmapped_zero_a: assert property (unmapped_rd |-> ##2 sfr_rdata_r == 16'h0000)
		else $error("unmapped read not zero");
endmodule // rfp_props
`default_nettype wire

// File: dv/rfp_rom_model.sv
// Purpose: Internal ROM model on the far side of the fetch path
// Assumes: Asynchronous read, one byte per address
// Notes: Contents are a fixed hash so neighbouring bytes differ
`timescale 1ns/1ps
`default_nettype none
module rfp_rom_model
(
	input  wire logic [19:0] addr,
	output      logic [7:0]  data
);
	// Hash, so a wrong address shows up as a wrong byte
	assign data = addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]};
endmodule // rfp_rom_model
`default_nettype wire

// File: hw/rfp_patch_unit.v
// Purpose: ROM fetch patch unit between CPU fetch path and internal ROM
// Assumes: ROM data is valid in the cycle of the fetch request; all inputs on core_clk
// Notes: One cycle latency on the fetch data path, two on register reads
//
// Summary of operation
// [R1] Control register: enables in bits 7..4, bits 3..2 zero, selector in 1..0.
// [R2] Selector 00..11 picks channel 0..3, bit 1 being the high bit.
// [R3] Writing address high or low loads only the selected channel's pointer.
// [R4] Per-channel enable: 0 disables comparison, 1 allows substitution on match.
// [R5] Compare only on instruction fetches from internal ROM, never on data reads.
// [R6] On match output FCH, FDH, FEH or FFH for channels 0 to 3.
// [R7] Substituted opcode branches through table entry 0078H, 007AH, 007CH or 007EH.
// [R8] Substitute is a one-byte table call saving three bytes on the stack.
// [R9] Patch routine adds 3 to stack pointer, then branches anywhere.
// [R10] No correction status flag; a discarded fetch leaves no visible state.
// [R11] Reset clears control register to 00H: all off, channel 0 selected.
// [R12] Control register takes single-bit and full-byte reads and writes.
// [R13] Pointers are 20 bits; lowest matching channel wins.
// [R14] Only the first opcode byte at the matching address is replaced.
`default_nettype none
`timescale 1ns/1ps
`include "rfp_regs.vh"

module rfp_patch_unit
(
	input  wire        core_clk,
	input  wire        resetn,
	// Special function register access
	input  wire [19:0] sfr_addr,
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire        sfr_word,
	input  wire        sfr_bit_op,
	input  wire [2:0]  sfr_bit_pos,
	input  wire        sfr_bit_val,
	input  wire [15:0] sfr_wdata,
	output reg  [15:0] sfr_rdata_r,
	output reg         sfr_rack_r,
	// Fetch path from CPU
	input  wire        fetch_req,
	input  wire [19:0] fetch_addr,
	input  wire        fetch_instr,
	input  wire        fetch_first,
	input  wire        fetch_internal,
	// Internal ROM output
	input  wire [7:0]  rom_data,
	// Toward CPU
	output reg  [7:0]  fetch_data_r,
	output reg         fetch_valid_r,
	output reg         table_call_r,
	output reg  [15:0] table_entry_r
);

	reg  [7:0]  ctrl_r;
	reg  [7:0]  ctrl_nxt;
	reg  [1:0]  rd_kind_r;
	reg         rd_req_r;
	reg  [15:0] rdata_nxt;
	reg  [7:0]  data_nxt;
	reg         call_nxt;
	reg  [15:0] entry_nxt;

	wire        hit_ctrl;
	wire        hit_lo;
	wire        hit_hi;
	wire        wr_lo;
	wire        wr_hi;
	wire        cmp_gate;
	wire [3:0]  match;
	wire [19:0] ptr_rd;
	wire [1:0]  win_ch;

	localparam RD_NONE = 2'b00;
	localparam RD_CTRL = 2'b01;
	localparam RD_LO   = 2'b10;
	localparam RD_HI   = 2'b11;

	// Address decode, used for reads and writes alike
	function addr_is;
		input [19:0] a;
		input [19:0] target;
		begin
			addr_is = (a == target);
		end
	endfunction

	// [R13] Lowest channel wins on multiple hits
	function [1:0] lowest_hit;
		input [3:0] m;
		begin
			if (m[0])
				lowest_hit = 2'd0;
			else if (m[1])
				lowest_hit = 2'd1;
			else if (m[2])
				lowest_hit = 2'd2;
			else
				lowest_hit = 2'd3;
		end
	endfunction

	// [R6] Channel to table call opcode
	function [7:0] chan_opcode;
		input [1:0] ch;
		begin
			case (ch)
				2'd0: chan_opcode = `RFP_OPC_CH0;
				2'd1: chan_opcode = `RFP_OPC_CH1;
				2'd2: chan_opcode = `RFP_OPC_CH2;
				default: chan_opcode = `RFP_OPC_CH3;
			endcase
		end
	endfunction

	// [R7] Channel to table entry address
	function [15:0] chan_entry;
		input [1:0] ch;
		begin
			case (ch)
				2'd0: chan_entry = `RFP_TBL_CH0;
				2'd1: chan_entry = `RFP_TBL_CH1;
				2'd2: chan_entry = `RFP_TBL_CH2;
				default: chan_entry = `RFP_TBL_CH3;
			endcase
		end
	endfunction

	assign hit_ctrl = addr_is(sfr_addr, `RFP_CTRL_ADDR);
	assign hit_lo   = addr_is(sfr_addr, `RFP_ADDRL_ADDR);
	assign hit_hi   = addr_is(sfr_addr, `RFP_ADDRH_ADDR);
	// Bit operations only reach the control register
	assign wr_lo    = sfr_wr && !sfr_bit_op && hit_lo;
	assign wr_hi    = sfr_wr && !sfr_bit_op && hit_hi;

	// [R12] Byte and single-bit writes
	always @*
	begin
		ctrl_nxt = ctrl_r;
		if (sfr_wr && hit_ctrl)
		begin
			if (sfr_bit_op)
				ctrl_nxt[sfr_bit_pos] = sfr_bit_val;
			else
				ctrl_nxt = sfr_wdata[7:0];
		end
		// [R1] Bits 3..2 are held at zero
		ctrl_nxt[`RFP_ZERO_MSB:`RFP_ZERO_LSB] = 2'b00;
	end

	// [R11] Reset clears control
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			ctrl_r <= `RFP_CTRL_RST;
		else
			ctrl_r <= ctrl_nxt;
	end

	// [R2] Selector drives pointer writes and reads
	rfp_ptr_bank u_bank
	(
		.core_clk  (core_clk),
		.resetn    (resetn),
		.wr_lo     (wr_lo),
		.wr_hi     (wr_hi),
		.wr_sel    (ctrl_r[`RFP_SEL_HI:`RFP_SEL_LO]),
		.wr_data   (sfr_wdata),
		.rd_sel    (ctrl_r[`RFP_SEL_HI:`RFP_SEL_LO]),
		.rd_data_r (ptr_rd),
		.cmp_addr  (fetch_addr),
		.cmp_en    (ctrl_r[`RFP_EN_MSB:`RFP_EN_LSB] & {4{cmp_gate}}),
		.match     (match)
	);

	// Read kind is remembered one cycle, so pointer data comes from the bank register
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_kind_r <= RD_NONE;
			rd_req_r  <= 1'b0;
		end
		else
		begin
			rd_req_r <= sfr_rd;
			if (sfr_rd && hit_ctrl)
				rd_kind_r <= RD_CTRL;
			else if (sfr_rd && hit_lo)
				rd_kind_r <= RD_LO;
			else if (sfr_rd && hit_hi)
				rd_kind_r <= RD_HI;
			else
				rd_kind_r <= RD_NONE;
		end
	end

	// [R12] Reads return the whole byte; bit reads pick from it
	always @*
	begin
		case (rd_kind_r)
			RD_CTRL: rdata_nxt = {8'h00, ctrl_r};
			RD_LO:   rdata_nxt = ptr_rd[`RFP_PTR_LO_MSB:0];
			RD_HI:   rdata_nxt = {12'h000, ptr_rd[`RFP_PTR_HI_MSB:`RFP_PTR_HI_LSB]};
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// Answer waits for the bank's read register; ack rides with the data
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sfr_rdata_r <= 16'h0000;
			sfr_rack_r  <= 1'b0;
		end
		else
		begin
			sfr_rack_r <= rd_req_r;
			// Unmapped reads fall to the zero default of rdata_nxt
			if (rd_req_r)
				sfr_rdata_r <= rdata_nxt;
		end
	end

	// [R5] Compare only instruction fetches from internal ROM
	// [R14] Only on the first opcode byte
	assign cmp_gate = fetch_req && fetch_instr && fetch_internal && fetch_first;
	assign win_ch   = lowest_hit(match);

	// [R6] Substitute the ROM byte on a hit
	// [R8] Opcode is a single byte table call; the CPU does the stacking
	always @*
	begin
		data_nxt  = rom_data;
		call_nxt  = 1'b0;
		entry_nxt = 16'h0000;
		if (|match)
		begin
			data_nxt  = chan_opcode(win_ch);
			call_nxt  = 1'b1;
			// [R7] Entry the CPU will branch through
			entry_nxt = chan_entry(win_ch);
		end
	end

	// [R10] No sticky flag; table_call_r and table_entry_r last one cycle, fetch_data_r keeps its byte until the next fetch
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fetch_data_r  <= 8'h00;
			fetch_valid_r <= 1'b0;
			table_call_r  <= 1'b0;
			table_entry_r <= 16'h0000;
		end
		else
		begin
			fetch_valid_r <= fetch_req;
			table_call_r  <= call_nxt;
			table_entry_r <= entry_nxt;
			if (fetch_req)
				fetch_data_r <= data_nxt;
		end
	end

endmodule // rfp_patch_unit

`default_nettype wire

// File: hw/rfp_ptr_bank.v
// Purpose: Four correction address pointers with compare logic
// Assumes: Write strobes come from the register decoder on core_clk
// Notes: Read data leaves through a register, match vector is combinational
`default_nettype none
`timescale 1ns/1ps
`include "rfp_regs.vh"

module rfp_ptr_bank
(
	input  wire        core_clk,
	input  wire        resetn,
	input  wire        wr_lo,
	input  wire        wr_hi,
	input  wire [1:0]  wr_sel,
	input  wire [15:0] wr_data,
	input  wire [1:0]  rd_sel,
	output reg  [19:0] rd_data_r,
	input  wire [19:0] cmp_addr,
	input  wire [3:0]  cmp_en,
	output wire [3:0]  match
);

	wire [79:0] ptr_flat;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_chan
			localparam integer CH_ID = g;
			reg [19:0] ptr_r;
			// [R3] Only the selected pointer loads
			always @(posedge core_clk or negedge resetn)
			begin
				if (!resetn)
					ptr_r <= `RFP_PTR_RST;
				else if (wr_sel == CH_ID[1:0])
				begin
					if (wr_lo)
						ptr_r[`RFP_PTR_LO_MSB:0] <= wr_data;
					if (wr_hi)
						ptr_r[`RFP_PTR_HI_MSB:`RFP_PTR_HI_LSB] <= wr_data[`RFP_PTR_HI_W-1:0];
				end
			end
			// [R4] Enable gates each comparator
			assign match[g] = cmp_en[g] && (ptr_r == cmp_addr);
			assign ptr_flat[g*20 +: 20] = ptr_r;
		end
	endgenerate

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rd_data_r <= `RFP_PTR_RST;
		else
			rd_data_r <= ptr_flat[rd_sel*20 +: 20];
	end

endmodule // rfp_ptr_bank

`default_nettype wire

// File: shared/rfp_regs.vh
// Purpose: Constants for the ROM fetch patch unit
// Assumes: 20-bit CPU address space, special function registers up to 16 bits wide
// Notes: Included by both design files
`ifndef RFP_REGS_VH
`define RFP_REGS_VH

// Register addresses
`define RFP_CTRL_ADDR      20'hff88
`define RFP_ADDRL_ADDR     20'hff8a
`define RFP_ADDRH_ADDR     20'hff8c

// Reset values
`define RFP_CTRL_RST       8'h00
`define RFP_PTR_RST        20'h00000

// Control register fields
`define RFP_EN_MSB         7
`define RFP_EN_LSB         4
`define RFP_ZERO_MSB       3
`define RFP_ZERO_LSB       2
`define RFP_SEL_HI         1
`define RFP_SEL_LO         0

// Pointer layout
`define RFP_PTR_W          20
`define RFP_PTR_LO_MSB     15
`define RFP_PTR_HI_MSB     19
`define RFP_PTR_HI_LSB     16
`define RFP_PTR_HI_W       4

// Substituted opcodes per channel
`define RFP_OPC_CH0        8'hfc
`define RFP_OPC_CH1        8'hfd
`define RFP_OPC_CH2        8'hfe
`define RFP_OPC_CH3        8'hff

// Table entries reached by each substituted opcode
`define RFP_TBL_CH0        16'h0078
`define RFP_TBL_CH1        16'h007a
`define RFP_TBL_CH2        16'h007c
`define RFP_TBL_CH3        16'h007e

// Bytes saved on the stack by a table call
`define RFP_STACK_SAVE     8'h03

`endif
